// ---- common/bit_test_call_consts.svh ----
`ifndef BIT_TEST_CALL_CONSTS_SVH
`define BIT_TEST_CALL_CONSTS_SVH

// reset values
`define BTC_PC_RST 10'h000
`define BTC_WORK_RST 8'h00
`define BTC_ZERO_RST 1'b0
`define BTC_PCHB_RST 8'h00
`define BTC_THP_RST 8'h00
`define BTC_FILE_RST 8'h00
`define BTC_PEEK_RST 8'h00
`define BTC_STACK_RST 10'h000

// field positions of the upper program counter source bits
`define BTC_UPPER_MSB 1
`define BTC_UPPER_LSB 0

// cycle counts
`define BTC_CALL_CYCLES 2
`define BTC_SKIP_CYCLES 2

`endif

// ---- common/bit_test_call_pkg.sv ----
package bit_test_call_pkg;

	typedef enum logic [2:0]
	{
		OP_NOP = 3'h0,
		OP_AND_IMMEDIATE = 3'h1,
		OP_BIT_SET = 3'h2,
		OP_SKIP_IF_BIT_CLEAR = 3'h3,
		OP_SKIP_IF_BIT_SET = 3'h4,
		OP_DIRECT_CALL = 3'h5,
		OP_INDIRECT_CALL = 3'h6
	} op_t;

	typedef enum logic [2:0]
	{
		ST_RUN = 3'h1,
		ST_SKIP = 3'h2,
		ST_CALL = 3'h4
	} exec_state_t;

endpackage

// ---- verilog/return_stack.sv ----
`timescale 1ns/1ns
`include "bit_test_call_consts.svh"

module return_stack #(
	parameter int DEPTH = 8,
	parameter int AW = 10,
	parameter int PW = $clog2(DEPTH)
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire logic [AW-1:0] push_data_i,
	output logic [PW-1:0] ptr_o,
	output logic [AW-1:0] top_o
);

	typedef struct packed {
		logic [DEPTH-1:0][AW-1:0] slot;
		logic [PW-1:0] ptr;
		logic [AW-1:0] top;
	} stack_state_t;

	stack_state_t cur_ff;
	stack_state_t nxt_ff;

	always_comb
	begin
		nxt_ff = cur_ff;
		if (push_i)
		begin
			// store at the current pointer, then advance; overflow wraps
			nxt_ff.slot[cur_ff.ptr] = push_data_i;
			nxt_ff.ptr = cur_ff.ptr + PW'(1);
			nxt_ff.top = push_data_i;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			cur_ff <= '0;
		else
			cur_ff <= nxt_ff;
	end

	assign ptr_o = cur_ff.ptr;
	assign top_o = cur_ff.top;

endmodule

// ---- verilog/bit_test_call_exec.sv ----
`timescale 1ns/1ns
`include "bit_test_call_consts.svh"

// Functional notes
// - and-immediate: working register gets AND, zero only
// - bit-set forces chosen file bit, flags untouched
// - skip-if-clear skips next when bit zero
// - skip-if-set skips next when bit one
// - skipped instruction discarded, no-op runs instead
// - calls push program counter plus one
// - direct call: immediate into pc low byte
// - direct call: pc high bits from buffer
// - store at pointer, then pointer plus one
// - indirect call: table pointer bits and working register
// - table high pointer supplies indirect upper bits
// - pc high buffer supplies direct upper bits
module bit_test_call_exec #(
	parameter int STACK_DEPTH = 8
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic instr_valid_i,
	input wire bit_test_call_pkg::op_t instr_op_i,
	input wire logic [5:0] instr_reg_i,
	input wire logic [2:0] instr_bit_i,
	input wire logic [7:0] instr_imm_i,
	input wire logic work_wr_i,
	input wire logic [7:0] work_data_i,
	input wire logic file_wr_i,
	input wire logic [5:0] file_wr_addr_i,
	input wire logic [7:0] file_wr_data_i,
	input wire logic pchb_wr_i,
	input wire logic [7:0] pchb_data_i,
	input wire logic thp_wr_i,
	input wire logic [7:0] thp_data_i,
	input wire logic [5:0] peek_addr_i,
	output logic instr_ready_o,
	output logic [9:0] pc_o,
	output logic [7:0] working_o,
	output logic zero_o,
	output logic [7:0] pc_high_buffer_o,
	output logic [7:0] table_high_pointer_o,
	output logic [7:0] peek_data_o,
	output logic skipping_o,
	output logic [$clog2(STACK_DEPTH)-1:0] stack_ptr_o,
	output logic [9:0] stack_top_o
);

	typedef struct packed {
		bit_test_call_pkg::exec_state_t state;
		logic ready;
		logic [9:0] pc;
		logic [7:0] work;
		logic zero;
		logic [7:0] pchb;
		logic [7:0] thp;
		logic [63:0][7:0] file;
		logic [7:0] peek;
	} exec_t;

	localparam exec_t EXEC_RST = '{
		state: bit_test_call_pkg::ST_RUN,
		ready: 1'b1,
		pc: `BTC_PC_RST,
		work: `BTC_WORK_RST,
		zero: `BTC_ZERO_RST,
		pchb: `BTC_PCHB_RST,
		thp: `BTC_THP_RST,
		file: {64{`BTC_FILE_RST}},
		peek: `BTC_PEEK_RST
	};

	exec_t cur_ff;
	exec_t nxt_ff;
	logic push;
	logic run_take;
	logic tested_bit;

	function automatic logic [9:0] pc_next(input logic [9:0] pc);
		pc_next = pc + 10'h001;
	endfunction

	function automatic logic [9:0] call_target(input logic [7:0] upper, input logic [7:0] low);
		call_target = {upper[`BTC_UPPER_MSB:`BTC_UPPER_LSB], low};
	endfunction

	function automatic logic file_bit(input logic [63:0][7:0] file, input logic [5:0] adr,
		input logic [2:0] sel);
		file_bit = file[adr][sel];
	endfunction

	assign run_take = instr_valid_i && (cur_ff.state == bit_test_call_pkg::ST_RUN);
	assign tested_bit = file_bit(cur_ff.file, instr_reg_i, instr_bit_i);

	always_comb
	begin
		nxt_ff = cur_ff;
		push = 1'b0;
		// side loads from the rest of the core; an and-immediate overrides a working load, a bit-set forces its bit on top of a file load
		if (work_wr_i)
			nxt_ff.work = work_data_i;
		if (file_wr_i)
			nxt_ff.file[file_wr_addr_i] = file_wr_data_i;
		if (pchb_wr_i)
			nxt_ff.pchb = pchb_data_i;
		if (thp_wr_i)
			nxt_ff.thp = thp_data_i;
		unique case (cur_ff.state)
			bit_test_call_pkg::ST_RUN:
			begin
				if (instr_valid_i)
				begin
					nxt_ff.pc = pc_next(cur_ff.pc);
					unique case (instr_op_i)
						bit_test_call_pkg::OP_AND_IMMEDIATE:
						begin
							nxt_ff.work = cur_ff.work & instr_imm_i;
							nxt_ff.zero = ((cur_ff.work & instr_imm_i) == 8'h00);
						end
						bit_test_call_pkg::OP_BIT_SET:
						begin
							nxt_ff.file[instr_reg_i][instr_bit_i] = 1'b1;
						end
						bit_test_call_pkg::OP_SKIP_IF_BIT_CLEAR:
						begin
							if (!tested_bit)
								nxt_ff.state = bit_test_call_pkg::ST_SKIP;
						end
						bit_test_call_pkg::OP_SKIP_IF_BIT_SET:
						begin
							if (tested_bit)
								nxt_ff.state = bit_test_call_pkg::ST_SKIP;
						end
						bit_test_call_pkg::OP_DIRECT_CALL:
						begin
							push = 1'b1;
							nxt_ff.pc = call_target(cur_ff.pchb, instr_imm_i);
							nxt_ff.state = bit_test_call_pkg::ST_CALL;
						end
						bit_test_call_pkg::OP_INDIRECT_CALL:
						begin
							push = 1'b1;
							nxt_ff.pc = call_target(cur_ff.thp, cur_ff.work);
							nxt_ff.state = bit_test_call_pkg::ST_CALL;
						end
						default:
						begin
							nxt_ff.pc = pc_next(cur_ff.pc);
						end
					endcase
				end
			end
			bit_test_call_pkg::ST_SKIP:
			begin
				// the prefetched word is taken and dropped; only the pc moves
				if (instr_valid_i)
				begin
					nxt_ff.pc = pc_next(cur_ff.pc);
					nxt_ff.state = bit_test_call_pkg::ST_RUN;
				end
			end
			bit_test_call_pkg::ST_CALL:
			begin
				// second call cycle: the stale fetch is flushed by holding ready low
				nxt_ff.state = bit_test_call_pkg::ST_RUN;
			end
			default:
			begin
				nxt_ff.state = bit_test_call_pkg::ST_RUN;
			end
		endcase
		nxt_ff.ready = (nxt_ff.state != bit_test_call_pkg::ST_CALL);
		nxt_ff.peek = nxt_ff.file[peek_addr_i];
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (rst_i)
			cur_ff <= EXEC_RST;
		else
			cur_ff <= nxt_ff;
	end

	return_stack #(
		.DEPTH(STACK_DEPTH),
		.AW(10)
	) u_stack (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.push_i(push),
		.push_data_i(pc_next(cur_ff.pc)),
		.ptr_o(stack_ptr_o),
		.top_o(stack_top_o)
	);

	assign instr_ready_o = cur_ff.ready;
	assign pc_o = cur_ff.pc;
	assign working_o = cur_ff.work;
	assign zero_o = cur_ff.zero;
	assign pc_high_buffer_o = cur_ff.pchb;
	assign table_high_pointer_o = cur_ff.thp;
	assign peek_data_o = cur_ff.peek;
	// one-hot: the skip state owns bit 1, so the output is that flop with no decode
	assign skipping_o = cur_ff.state[1];

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	logic take_and;
	logic take_set;
	logic take_skc;
	logic take_sks;
	logic take_call;
	logic take_dcall;
	logic take_icall;

	assign take_and = run_take && (instr_op_i == bit_test_call_pkg::OP_AND_IMMEDIATE);
	assign take_set = run_take && (instr_op_i == bit_test_call_pkg::OP_BIT_SET);
	assign take_skc = run_take && (instr_op_i == bit_test_call_pkg::OP_SKIP_IF_BIT_CLEAR);
	assign take_sks = run_take && (instr_op_i == bit_test_call_pkg::OP_SKIP_IF_BIT_SET);
	assign take_dcall = run_take && (instr_op_i == bit_test_call_pkg::OP_DIRECT_CALL);
	assign take_icall = run_take && (instr_op_i == bit_test_call_pkg::OP_INDIRECT_CALL);
	assign take_call = take_dcall || take_icall;

	sequence call_bubble;
		!instr_ready_o ##1 instr_ready_o;
	endsequence

	sequence skip_drop;
		skipping_o && instr_ready_o ##1 !skipping_o;
	endsequence

	AST_AND_RESULT: assert property (take_and |=>
		working_o == ($past(working_o) & $past(instr_imm_i)) && zero_o == (working_o == 8'h00))
		else $error("and-immediate result or zero flag wrong");

	AST_ZERO_ONLY_AND: assert property (!take_and |=> $stable(zero_o))
		else $error("zero flag changed outside and-immediate");

	AST_BIT_SET: assert property (take_set |=>
		cur_ff.file[$past(instr_reg_i)][$past(instr_bit_i)] && $stable(zero_o))
		else $error("bit-set did not force the bit");

	AST_SKIP_CLEAR: assert property (take_skc |=> skipping_o == !$past(tested_bit))
		else $error("skip-if-clear decision wrong");

	AST_SKIP_SET: assert property (take_sks |=> skipping_o == $past(tested_bit))
		else $error("skip-if-set decision wrong");

	AST_SKIP_NOP: assert property (skipping_o && instr_valid_i && !work_wr_i |=>
		pc_o == pc_next($past(pc_o)) && $stable(working_o) && $stable(stack_ptr_o))
		else $error("skipped slot did more than advance the pc");

	AST_SKIP_TWO: assert property ((take_skc || take_sks) && instr_op_i != 3'h0 ##1 skipping_o
		&& instr_valid_i |-> skip_drop)
		else $error("skip did not end after one dropped slot");

	AST_CALL_PUSH: assert property (take_call |=>
		stack_ptr_o == $past(stack_ptr_o) + 1'b1 && stack_top_o == pc_next($past(pc_o)))
		else $error("call push wrong");

	AST_CALL_BUBBLE: assert property (take_call |=> call_bubble)
		else $error("call did not take two cycles");

	AST_DIRECT_PC: assert property (take_dcall |=>
		pc_o == call_target($past(cur_ff.pchb), $past(instr_imm_i)))
		else $error("direct call target wrong");

	AST_INDIRECT_PC: assert property (take_icall |=>
		pc_o == call_target($past(cur_ff.thp), $past(working_o)))
		else $error("indirect call target wrong");

endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ns
module testbench;
	logic clk_sys_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0;
	bit_test_call_pkg::op_t instr_op_i = bit_test_call_pkg::OP_NOP;
	logic [5:0] instr_reg_i = 6'h00, file_wr_addr_i = 6'h00, peek_addr_i = 6'h00;
	logic [2:0] instr_bit_i = 3'h0;
	logic [7:0] instr_imm_i = 8'h00, work_data_i = 8'h00, file_wr_data_i = 8'h00;
	logic [7:0] pchb_data_i = 8'h00, thp_data_i = 8'h00;
	logic work_wr_i = 1'b0, file_wr_i = 1'b0, pchb_wr_i = 1'b0, thp_wr_i = 1'b0;
	logic instr_ready_o, zero_o, skipping_o;
	logic [9:0] pc_o, stack_top_o;
	logic [7:0] working_o, pc_high_buffer_o, table_high_pointer_o, peek_data_o;
	logic [2:0] stack_ptr_o;
	int fails = 0, compares = 0, seed = 62;
	logic [31:0] r, q;
	logic [9:0] m_pc, m_top;
	logic [7:0] m_wk, m_ph, m_th, m_pk, nw;
	logic [7:0] m_fr [64];
	logic [2:0] m_sp;
	logic m_z, m_rdy, m_skp, iw, ifw;

	bit_test_call_exec #(.STACK_DEPTH(8)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .instr_reg_i(instr_reg_i),
		.instr_bit_i(instr_bit_i), .instr_imm_i(instr_imm_i), .work_wr_i(work_wr_i),
		.work_data_i(work_data_i), .file_wr_i(file_wr_i), .file_wr_addr_i(file_wr_addr_i),
		.file_wr_data_i(file_wr_data_i), .pchb_wr_i(pchb_wr_i), .pchb_data_i(pchb_data_i),
		.thp_wr_i(thp_wr_i), .thp_data_i(thp_data_i), .peek_addr_i(peek_addr_i),
		.instr_ready_o(instr_ready_o), .pc_o(pc_o), .working_o(working_o), .zero_o(zero_o),
		.pc_high_buffer_o(pc_high_buffer_o), .table_high_pointer_o(table_high_pointer_o),
		.peek_data_o(peek_data_o), .skipping_o(skipping_o), .stack_ptr_o(stack_ptr_o),
		.stack_top_o(stack_top_o));

	always #20 clk_sys_i = ~clk_sys_i;

	task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("fails %0d compares %0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic model_reset();
		m_pc = 10'h000;
		m_top = 10'h000;
		{m_wk, m_ph, m_th, m_pk, m_sp, m_z, m_skp} = '0;
		m_rdy = 1'b1;
		foreach (m_fr[k])
			m_fr[k] = 8'h00;
	endtask

	// the model works from the values before the edge; an and-immediate overrides a
	// same-cycle working load, a bit-set forces its bit on top of a same-cycle file load
	task automatic model_step();
		iw = 1'b0;
		ifw = 1'b0;
		nw = m_wk & instr_imm_i;
		if (!m_rdy)
			m_rdy = 1'b1;
		else if (m_skp)
		begin
			if (instr_valid_i)
			begin
				m_pc = m_pc + 10'h001;
				m_skp = 1'b0;
			end
		end
		else if (instr_valid_i)
		begin
			m_pc = m_pc + 10'h001;
			case (instr_op_i)
				3'h1: iw = 1'b1;
				3'h2: ifw = 1'b1;
				3'h3: m_skp = !m_fr[instr_reg_i][instr_bit_i];
				3'h4: m_skp = m_fr[instr_reg_i][instr_bit_i];
				3'h5, 3'h6:
				begin
					m_top = m_pc;
					m_sp = m_sp + 3'h1;
					m_rdy = 1'b0;
					m_pc = (instr_op_i == 3'h5) ? {m_ph[1:0], instr_imm_i}
						: {m_th[1:0], m_wk};
				end
				default: m_top = m_top;
			endcase
		end
		if (work_wr_i)
			m_wk = work_data_i;
		if (file_wr_i)
			m_fr[file_wr_addr_i] = file_wr_data_i;
		if (pchb_wr_i)
			m_ph = pchb_data_i;
		if (thp_wr_i)
			m_th = thp_data_i;
		if (iw)
		begin
			m_wk = nw;
			m_z = (nw == 8'h00);
		end
		if (ifw)
			m_fr[instr_reg_i][instr_bit_i] = 1'b1;
		m_pk = m_fr[peek_addr_i];
	endtask

	initial
	begin
		model_reset();
		repeat (4) @(posedge clk_sys_i);
		#1;
		for (int i = 0; i < 3000; i++)
		begin
			r = $random(seed);
			q = $random(seed);
			rst_i = (i % 1000 == 999);
			instr_valid_i = r[2:0] != 3'h0;
			instr_op_i = bit_test_call_pkg::op_t'(r[5:3]);
			// registers at both ends of the file, so side loads often collide
			instr_reg_i = {{3{r[9]}}, r[8:6]};
			instr_bit_i = r[12:10];
			instr_imm_i = r[20:13];
			work_wr_i = r[22:21] == 2'h0;
			file_wr_i = r[24:23] == 2'h0;
			pchb_wr_i = r[26:25] == 2'h0;
			thp_wr_i = r[28:27] == 2'h0;
			work_data_i = q[7:0];
			file_wr_data_i = q[15:8];
			file_wr_addr_i = {{3{q[19]}}, q[18:16]};
			pchb_data_i = q[27:20];
			thp_data_i = {q[31:28], r[31:28]};
			peek_addr_i = {{3{q[30]}}, r[31:29]};
			if (rst_i)
				model_reset();
			else
				model_step();
			@(posedge clk_sys_i);
			#1;
			chk({9'h000, instr_ready_o}, {9'h000, m_rdy}, "ready");
			chk(pc_o, m_pc, "pc");
			chk({2'h0, working_o}, {2'h0, m_wk}, "work");
			chk({9'h000, zero_o}, {9'h000, m_z}, "zero");
			chk({2'h0, pc_high_buffer_o}, {2'h0, m_ph}, "pchb");
			chk({2'h0, table_high_pointer_o}, {2'h0, m_th}, "thp");
			chk({2'h0, peek_data_o}, {2'h0, m_pk}, "peek");
			chk({9'h000, skipping_o}, {9'h000, m_skp}, "skip");
			chk({7'h00, stack_ptr_o}, {7'h00, m_sp}, "sp");
			chk(stack_top_o, m_top, "top");
		end
		complete_run();
	end

	// the run needs about 3000 cycles; twice that means a hang
	initial
	begin
		#250000;
		fails++;
		complete_run();
	end
endmodule
